//--- inc/pfd_pkg.sv
// constants and types for the fault input and delay block
`default_nettype none
package pfd_pkg;
   // ---------------------------------------------------------------
   // register indices (byte address = index * 4)
   // ---------------------------------------------------------------
   localparam logic [5:0] IDX_IN_A   = 6'h10;
   localparam logic [5:0] IDX_IN_B   = 6'h11;
   localparam logic [5:0] IDX_FAULT  = 6'h12;
   localparam logic [5:0] IDX_DLY_C  = 6'h14;
   localparam logic [5:0] IDX_DLY_V  = 6'h15;
   localparam logic [5:0] IDX_CMD    = 6'h16;
   localparam logic [5:0] IDX_EDGE   = 6'h17;
   localparam logic [5:0] IDX_STATUS = 6'h18;
   // command register keys, values arbitrary
   localparam logic [7:0] KEY_UNLOCK = 8'hd8;
   localparam logic [7:0] KEY_RESUME = 8'h5a;
   // ---------------------------------------------------------------
   // reaction codes
   // ---------------------------------------------------------------
   localparam logic [3:0] RC_NONE      = 4'h0;
   localparam logic [3:0] RC_JUMP      = 4'h1;
   localparam logic [3:0] RC_RUN_HOLD  = 4'h2;
   localparam logic [3:0] RC_RUN_FAULT = 4'h3;
   localparam logic [3:0] RC_KEEP_RATE = 4'h4;
   localparam logic [3:0] RC_DEADTIME  = 4'h5;
   localparam logic [3:0] RC_NEXT_HOLD = 4'h6;
   localparam logic [3:0] RC_SW_HOLD   = 4'h7;
   localparam logic [3:0] RC_EDGE_ADV  = 4'h8;
   localparam logic [3:0] RC_EDGE_RATE = 4'h9;
   localparam logic [3:0] RC_LVL_RATE  = 4'ha;
   // ---------------------------------------------------------------
   // delay function codes
   // ---------------------------------------------------------------
   localparam logic [1:0] DF_OFF   = 2'h0;
   localparam logic [1:0] DF_BLANK = 2'h1;
   localparam logic [1:0] DF_EVENT = 2'h2;
   localparam logic [1:0] DF_RSV   = 2'h3;
   localparam logic [2:0] PCNT_ZERO = 3'h0;
   localparam logic [2:0] PCNT_ONE  = 3'h1;
   localparam logic [7:0] DCNT_ONE  = 8'h01;
   localparam logic [7:0] DVAL_ZERO = 8'h00;
   localparam logic [7:0] FLT_POR   = 8'h00;
   // status bit positions
   localparam int ST_SW_HOLD = 0;
   localparam int ST_BLANK   = 1;
   localparam int ST_DLY_RUN = 2;
   localparam int ST_UNLOCK  = 3;
   localparam int ST_LATCH   = 4;
   localparam int ST_STOP    = 8;
   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [3:0] pin_en;
      logic [3:0] def_lvl;
   } pfd_fault_cfg_t;
   typedef struct packed {
      logic [1:0] rsv;
      logic [1:0] presc;
      logic [1:0] trig;
      logic [1:0] func;
   } pfd_dly_cfg_t;
   // bit 0 is match a set, matching the trigger code order
   typedef struct packed {
      logic b_clr;
      logic b_set;
      logic a_clr;
      logic a_set;
   } pfd_match_t;
   typedef struct packed {
      logic jump_opposite;
      logic run_opposite;
      logic advance;
      logic hold;
      logic deadtime;
   } pfd_seq_req_t;
   typedef enum logic {
      DLY_IDLE = 1'b0,
      DLY_RUN  = 1'b1
   } pfd_dly_st_t;
endpackage
`default_nettype wire

//--- logic/pfd_fault_delay.sv
// fault input reactions, output fault config and delay unit
//
// Summary of operation
// - inputs a and b each own a 4-bit reaction code; 0 means no effect
// - code 1 stops output, jumps to opposite cycle, holds while active
// - code 2 stops output, runs opposite cycle, then holds
// - code 3 stops output, runs opposite cycle while fault stays active
// - code 4 stops all outputs, counter keeps running
// - code 5 stops all outputs, sequence stays in dead time while active
// - code 6 stops all outputs, advances to next cycle and holds
// - code 7 stops all outputs until software resumes
// - code 8 edge stops own output and advances to next cycle
// - code 9 edge stops own output, counter undisturbed
// - code 10 level stops own output, counter undisturbed
// - upper fault config bits enable outputs a-d onto pins
// - lower fault config bits give output levels at reset and fault
// - power-on clears fault config; other resets load it from fuse
// - fault config writes need the unlock sequence first
// - delay prescaler divides by 1, 2, 4 or 8
// - delay start source picks one of four compare matches
// - delay function: off, input blanking, delayed event; 3 reserved
// - 8-bit delay value counted in prescaled cycles
// - inputs qualified by edge select: 0 falling/low, 1 rising/high
//
// notes for the next user
// - each register access takes two cycles; waitrequest drops for one cycle
// - read data is captured at the taking edge and stands until the next read
// - a fault config write lands only right after an accepted unlock key write
// - the unlock lasts until the next accepted write of any kind
// - input a stops output a and its opposite cycle is b; input b the reverse
// - hold requests of codes 1, 2 and 6 last while the input stays active
// - edge codes keep their stop until the end of cycle; a new edge wins
// - a software hold set in the same cycle as a resume stays set
// - reserved delay function 3 acts as off and never starts the unit
// - a start while the delay runs reloads the full value
// - a zero delay value gives the event on the cycle after the start
// - blanked inputs are ignored, so a fault still active when blanking ends
//   shows a fresh edge then
//
// Local design decision: the Avalon-MM interface to the registers.
`default_nettype none
module pfd_fault_delay (
   input  wire logic                  clk_sys,
   input  wire logic                  rst,
   input  wire logic                  por_flag,
   input  wire logic [7:0]            timer_config_fuse,
   input  wire logic [7:0]            avs_address,
   input  wire logic                  avs_read,
   input  wire logic                  avs_write,
   input  wire logic [31:0]           avs_writedata,
   input  wire logic [3:0]            avs_byteenable,
   output logic [31:0]                avs_readdata,
   output logic                       avs_waitrequest,
   input  wire logic [1:0]            fault_in,
   input  wire logic [3:0]            wave_raw,
   input  wire pfd_pkg::pfd_match_t   match,
   output logic [3:0]                 pin_level,
   output logic [3:0]                 pin_oe,
   output pfd_pkg::pfd_seq_req_t      seq_req_a,
   output pfd_pkg::pfd_seq_req_t      seq_req_b,
   output logic                       blanking,
   output logic                       delayed_event
);
   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      // bus side
      logic                    busy;
      logic [31:0]             rdata;
      // software registers
      pfd_pkg::pfd_fault_cfg_t flt;
      logic [3:0]              mode_a;
      logic [3:0]              mode_b;
      pfd_pkg::pfd_dly_cfg_t   dcfg;
      logic [7:0]              dval;
      logic [1:0]              edge_sel;
      logic                    unlocked;
      // input reaction state
      logic [1:0]              act_prev;
      logic [1:0]              latch;
      logic                    sw_hold;
      // delay unit
      pfd_pkg::pfd_dly_st_t    dst;
      logic [2:0]              pcnt;
      logic [7:0]              dcnt;
      logic                    blank;
      logic                    dly_evt;
      // registered outputs
      pfd_pkg::pfd_seq_req_t   seq_a;
      pfd_pkg::pfd_seq_req_t   seq_b;
      logic [3:0]              stop;
      logic [3:0]              lvl;
      logic [3:0]              oe;
   } pfd_state_t;

   pfd_state_t s;
   pfd_state_t next_s;

   // ---------------------------------------------------------------
   // functions
   // ---------------------------------------------------------------
   // register hit on a word-aligned byte address
   function automatic logic hit(input logic [7:0] a, input logic [5:0] idx);
      hit = (a == {idx, 2'b00});
   endfunction

   // active level of an input under its edge select
   function automatic logic qual(input logic lvl, input logic sel);
      qual = (lvl == sel);
   endfunction

   // prescaler terminal count mask
   // code p ticks when the low p prescaler bits are all set
   function automatic logic [2:0] pmask(input logic [1:0] p);
      pmask = 3'h0;
      for (int k = 0; k < 3; k++) begin
         if (k < int'(p)) begin
            pmask[k] = 1'b1;
         end
      end
   endfunction

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      logic                  acc;
      logic                  wr_ok;
      logic [7:0]            wd;
      logic [3:0]            m;
      logic                  act;
      logic                  rise;
      logic                  stop_own;
      logic [3:0]            stop_all;
      logic                  sw_set;
      logic                  resume;
      logic                  eoc;
      logic                  trig;
      logic                  start;
      pfd_pkg::pfd_seq_req_t rq;
      logic [31:0]           rd;
      next_s = s;
      // request decode and per-cycle defaults
      acc = (avs_read | avs_write) & s.busy;
      wr_ok = avs_write & ~s.busy & avs_byteenable[0];
      wd = avs_writedata[7:0];
      stop_all = 4'h0;
      sw_set = 1'b0;
      resume = 1'b0;
      eoc = match.b_clr;
      next_s.dly_evt = 1'b0;
      // defaults so that no path leaves a variable open
      m = pfd_pkg::RC_NONE;
      act = 1'b0;
      rise = 1'b0;
      stop_own = 1'b0;
      trig = 1'b0;
      start = 1'b0;
      rq = '0;

      // bus answer: waitrequest drops one cycle after a request
      next_s.busy = ~acc;
      // read mux; the word is taken at the edge that takes the request
      rd = 32'h0;
      if (hit(avs_address, pfd_pkg::IDX_IN_A)) begin
         rd[3:0] = s.mode_a;
      end else if (hit(avs_address, pfd_pkg::IDX_IN_B)) begin
         rd[3:0] = s.mode_b;
      end else if (hit(avs_address, pfd_pkg::IDX_FAULT)) begin
         rd[7:0] = s.flt;
      end else if (hit(avs_address, pfd_pkg::IDX_DLY_C)) begin
         rd[5:0] = s.dcfg[5:0];
      end else if (hit(avs_address, pfd_pkg::IDX_DLY_V)) begin
         rd[7:0] = s.dval;
      end else if (hit(avs_address, pfd_pkg::IDX_EDGE)) begin
         rd[1:0] = s.edge_sel;
      end else if (hit(avs_address, pfd_pkg::IDX_STATUS)) begin
         rd[pfd_pkg::ST_SW_HOLD] = s.sw_hold;
         rd[pfd_pkg::ST_BLANK] = s.blank;
         rd[pfd_pkg::ST_DLY_RUN] = (s.dst == pfd_pkg::DLY_RUN);
         rd[pfd_pkg::ST_UNLOCK] = s.unlocked;
         rd[pfd_pkg::ST_LATCH +: 2] = s.latch;
         rd[pfd_pkg::ST_STOP +: 4] = s.stop;
      end
      if (acc && avs_read) begin
         next_s.rdata = rd;
      end

      // register writes
      if (wr_ok) begin
         // any accepted write ends an unlock; only the key renews it
         next_s.unlocked = 1'b0;
         if (hit(avs_address, pfd_pkg::IDX_IN_A)) begin
            next_s.mode_a = wd[3:0];
         end
         if (hit(avs_address, pfd_pkg::IDX_IN_B)) begin
            next_s.mode_b = wd[3:0];
         end
         if (hit(avs_address, pfd_pkg::IDX_FAULT) && s.unlocked) begin
            next_s.flt = wd;
         end
         if (hit(avs_address, pfd_pkg::IDX_DLY_C)) begin
            next_s.dcfg = {2'b00, wd[5:0]};
         end
         if (hit(avs_address, pfd_pkg::IDX_DLY_V)) begin
            next_s.dval = wd;
         end
         if (hit(avs_address, pfd_pkg::IDX_EDGE)) begin
            next_s.edge_sel = wd[1:0];
         end
         // command keys: unlock and software resume
         if (hit(avs_address, pfd_pkg::IDX_CMD)) begin
            next_s.unlocked = (wd == pfd_pkg::KEY_UNLOCK);
            resume = (wd == pfd_pkg::KEY_RESUME);
         end
      end

      // per-input reactions
      for (int i = 0; i < 2; i++) begin
         m = (i == 0) ? s.mode_a : s.mode_b;
         // qualified level of the input and its rising edge
         act = ~s.blank & qual(fault_in[i], s.edge_sel[i]);
         rise = act & ~s.act_prev[i];
         next_s.act_prev[i] = act;
         stop_own = 1'b0;
         rq = '0;
         // codes outside the table fall to the default branch
         case (m)
            pfd_pkg::RC_JUMP: begin
               stop_own = act;
               rq.jump_opposite = rise;
               rq.hold = act;
            end
            pfd_pkg::RC_RUN_HOLD: begin
               stop_own = act;
               rq.run_opposite = rise;
               rq.hold = act;
            end
            pfd_pkg::RC_RUN_FAULT: begin
               stop_own = act;
               rq.run_opposite = act;
            end
            pfd_pkg::RC_KEEP_RATE: begin
               stop_all = stop_all | {4{act}};
            end
            pfd_pkg::RC_DEADTIME: begin
               stop_all = stop_all | {4{act}};
               rq.deadtime = act;
            end
            pfd_pkg::RC_NEXT_HOLD: begin
               stop_all = stop_all | {4{act}};
               rq.advance = rise;
               rq.hold = act;
            end
            pfd_pkg::RC_SW_HOLD: begin
               stop_all = stop_all | {4{act}};
               sw_set = sw_set | rise;
            end
            pfd_pkg::RC_EDGE_ADV: begin
               stop_own = rise | s.latch[i];
               rq.advance = rise;
            end
            pfd_pkg::RC_EDGE_RATE: begin
               stop_own = rise | s.latch[i];
            end
            pfd_pkg::RC_LVL_RATE: begin
               stop_own = act;
            end
            default: begin
               stop_own = 1'b0;
            end
         endcase
         // edge latch holds the stop to end of cycle; set wins
         if ((m == pfd_pkg::RC_EDGE_ADV) || (m == pfd_pkg::RC_EDGE_RATE)) begin
            next_s.latch[i] = rise | (s.latch[i] & ~eoc);
         end else begin
            next_s.latch[i] = 1'b0;
         end
         // own stop lands on the output of the same letter
         stop_all[i] = stop_all[i] | stop_own;
         // sequencer requests go out registered
         if (i == 0) begin
            next_s.seq_a = rq;
         end else begin
            next_s.seq_b = rq;
         end
      end

      // software hold: set wins over resume
      next_s.sw_hold = sw_set | (s.sw_hold & ~resume);
      stop_all = stop_all | {4{s.sw_hold}};
      next_s.stop = stop_all;

      // pin drive from fault config
      // one bit per compare output a to d
      for (int k = 0; k < 4; k++) begin
         next_s.lvl[k] = stop_all[k] ? s.flt.def_lvl[k] : wave_raw[k];
         next_s.oe[k] = s.flt.pin_en[k];
      end

      // delay unit
      trig = match[s.dcfg.trig];
      // off and reserved functions never start the unit
      start = trig && (s.dcfg.func == pfd_pkg::DF_BLANK
                       || s.dcfg.func == pfd_pkg::DF_EVENT);
      // one counter tick per prescaled cycle; the last tick ends the delay
      unique case (s.dst)
         pfd_pkg::DLY_IDLE: begin
            next_s.blank = 1'b0;
         end
         pfd_pkg::DLY_RUN: begin
            if ((s.pcnt & pmask(s.dcfg.presc)) == pmask(s.dcfg.presc)) begin
               next_s.pcnt = pfd_pkg::PCNT_ZERO;
               if (s.dcnt <= pfd_pkg::DCNT_ONE) begin
                  next_s.dst = pfd_pkg::DLY_IDLE;
                  next_s.blank = 1'b0;
                  next_s.dly_evt = (s.dcfg.func == pfd_pkg::DF_EVENT);
               end else begin
                  next_s.dcnt = s.dcnt - pfd_pkg::DCNT_ONE;
               end
            end else begin
               next_s.pcnt = s.pcnt + pfd_pkg::PCNT_ONE;
            end
         end
      endcase

      // a start restarts a running delay from the full value
      if (start) begin
         next_s.pcnt = pfd_pkg::PCNT_ZERO;
         if (s.dval == pfd_pkg::DVAL_ZERO) begin
            next_s.dst = pfd_pkg::DLY_IDLE;
            next_s.blank = 1'b0;
            next_s.dly_evt = (s.dcfg.func == pfd_pkg::DF_EVENT);
         end else begin
            next_s.dst = pfd_pkg::DLY_RUN;
            next_s.dcnt = s.dval;
            next_s.blank = (s.dcfg.func == pfd_pkg::DF_BLANK);
         end
      end

      // synchronous reset; fault config from fuse unless power-on
      if (rst) begin
         next_s = '0;
         // waitrequest stands high while idle, also through reset
         next_s.busy = 1'b1;
         next_s.flt = por_flag ? pfd_pkg::FLT_POR : timer_config_fuse;
         // pins show the fault config from the first cycle after reset
         next_s.lvl = next_s.flt.def_lvl;
         next_s.oe = next_s.flt.pin_en;
      end
   end

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   // one register stage holds all state
   always_ff @(posedge clk_sys) begin
      s <= next_s;
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   // outputs straight from state flops
   assign avs_readdata = s.rdata;
   assign avs_waitrequest = s.busy;
   assign pin_level = s.lvl;
   assign pin_oe = s.oe;
   assign seq_req_a = s.seq_a;
   assign seq_req_b = s.seq_b;
   assign blanking = s.blank;
   assign delayed_event = s.dly_evt;
endmodule
`default_nettype wire

//--- sim/pfd_checker.sv
// concurrent checks on the ports of the fault input and delay block
`default_nettype none
module pfd_checker (
   input wire logic                  clk_sys,
   input wire logic                  rst,
   input wire logic                  avs_read,
   input wire logic                  avs_write,
   input wire logic                  avs_waitrequest,
   input wire logic [31:0]           avs_readdata,
   input wire logic [3:0]            pin_oe,
   input wire pfd_pkg::pfd_match_t   match,
   input wire pfd_pkg::pfd_seq_req_t seq_req_a,
   input wire logic                  blanking,
   input wire logic                  delayed_event
);
   // ------------------------------
   // helpers and assertions
   // ------------------------------
   logic req;
   logic wr_done;
   logic any_match;
   // request, accepted write and any match strobe
   assign req       = avs_read | avs_write;
   assign wr_done   = avs_write & ~avs_waitrequest;
   assign any_match = |match;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   ans_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("bus answer held longer than one cycle");
   ans_cause_a: assert property ($fell(avs_waitrequest) |-> $past(req))
      else $error("bus answer without a request");
   idle_wait_a: assert property (avs_waitrequest && !req |=> avs_waitrequest)
      else $error("bus answer while idle");
   rdata_hold_a: assert property (!avs_read |=> $stable(avs_readdata))
      else $error("read data moved without a read");
   oe_write_a: assert property (
      $changed(pin_oe) |-> $past(wr_done) || $past(wr_done, 2))
      else $error("pin enables moved without a register write");
   dly_pulse_a: assert property (delayed_event |=> !delayed_event)
      else $error("delayed event longer than one cycle");
   blank_cause_a: assert property (
      $rose(blanking) |-> $past(any_match) || $past(any_match, 2))
      else $error("blanking started without a match");
   jump_pulse_a: assert property (
      seq_req_a.jump_opposite |=> !seq_req_a.jump_opposite)
      else $error("jump request longer than one cycle");
endmodule
`default_nettype wire

//--- sim/pfd_partner.sv
// model of the fault inputs, raw waveform and compare match sources
`default_nettype none
module pfd_partner (
   input  wire logic           clk_sys,
   output logic [1:0]          fault_in,
   output logic [3:0]          wave_raw,
   output pfd_pkg::pfd_match_t match
);
   timeunit 1ns;
   timeprecision 1ps;
   // inputs start inactive for the low-active default
   initial begin
      fault_in = 2'h3;
      wave_raw = 4'h0;
      match    = '0;
   end
   // one match source pulses for exactly one cycle
   task automatic pulse(input int k);
      @(posedge clk_sys);
      match <= pfd_pkg::pfd_match_t'(4'h1 << k);
      @(posedge clk_sys);
      match <= '0;
   endtask
   // new input levels after the next edge
   task automatic drive(input logic [1:0] f, input logic [3:0] w);
      @(posedge clk_sys);
      fault_in <= f;
      wave_raw <= w;
   endtask
endmodule
`default_nettype wire

//--- sim/tb_top.sv
// self-checking bench for the fault input and delay block
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic                  clk_sys = 1'b0;
   logic                  rst = 1'b1;
   logic                  por_flag = 1'b1;
   logic [7:0]            fuse = 8'h00;
   logic [7:0]            avs_address = 8'h00;
   logic                  avs_read = 1'b0;
   logic                  avs_write = 1'b0;
   logic [31:0]           avs_writedata = 32'h0;
   logic [31:0]           avs_readdata;
   logic                  avs_waitrequest;
   logic [1:0]            fault_in;
   logic [3:0]            wave_raw, pin_level, pin_oe;
   pfd_pkg::pfd_match_t   match;
   pfd_pkg::pfd_seq_req_t seq_req_a, seq_req_b;
   logic                  blanking, delayed_event;
   logic [7:0]            exp_q[$];
   logic [7:0]            v;
   logic [5:0]            ra [5] = '{6'h10, 6'h11, 6'h12, 6'h14, 6'h15};
   logic [7:0]            rm [5] = '{8'h0f, 8'h0f, 8'h00, 8'h3f, 8'hff};
   logic [3:0]            tc [13] = '{4'h0, 4'hb, 4'hc, 4'hd, 4'he, 4'hf,
                                      4'h4, 4'h5, 4'h1, 4'h6, 4'h3, 4'ha, 4'h2};
   logic [11:0]           ev [13] = '{12'ha00, 12'ha00, 12'ha00, 12'ha00, 12'ha00, 12'ha00,
                                      12'h500, 12'h501, 12'hb02, 12'h502, 12'hb08, 12'hb00,
                                      12'hb02};
   int                    n_fail = 0, checks = 0, cyc = 0, seed = 21649, n;
   always #2 clk_sys = ~clk_sys;
   pfd_fault_delay u_dut (.clk_sys, .rst, .por_flag, .timer_config_fuse(fuse), .avs_address,
      .avs_read, .avs_write, .avs_writedata, .avs_byteenable(4'hf), .avs_readdata,
      .avs_waitrequest, .fault_in, .wave_raw, .match, .pin_level, .pin_oe, .seq_req_a,
      .seq_req_b, .blanking, .delayed_event);
   pfd_partner u_env (.clk_sys, .fault_in, .wave_raw, .match);
   task automatic print_verdict;
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // one register cycle, held until waitrequest is sampled low
   task automatic bus(input logic w, input logic [5:0] idx, input logic [7:0] d,
                      input logic [7:0] e);
      @(posedge clk_sys);
      if (!w) exp_q.push_back(e);
      avs_address   <= {idx, 2'h0};
      avs_writedata <= {24'h0, d};
      avs_read      <= !w;
      avs_write     <= w;
      @(posedge clk_sys);
      while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic see(input int c);
      repeat (c) @(posedge clk_sys);
      #1;
   endtask
   // read answers against the oldest queued note
   always @(posedge clk_sys) begin
      if (avs_read && avs_waitrequest === 1'b0) begin
         checks++;
         if (exp_q.size() == 0 || avs_readdata !== {24'h0, exp_q[0]}) begin
            n_fail++;
            $display("ERROR %0t: read data %h", $time, avs_readdata);
         end
         if (exp_q.size() != 0) void'(exp_q.pop_front());
      end
   end
   // hang guard
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         print_verdict();
      end
   end
   // main sequence
   initial begin
      repeat (6) @(posedge clk_sys);
      rst <= 1'b0;
      #1;
      chk({4'h0, pin_oe, pin_level}, 12'h000);
      for (int i = 0; i < 5; i++) bus(1'b0, ra[i], 8'h0, 8'h0);
      for (int i = 0; i < 5; i++) begin
         v = 8'($random(seed)) & rm[i];
         bus(1'b1, ra[i], v, 8'h0);
         bus(1'b0, ra[i], 8'h0, v);
      end
      bus(1'b1, 6'h14, 8'h0, 8'h0);
      bus(1'b1, 6'h20, 8'h5a, 8'h0);
      bus(1'b0, 6'h20, 8'h0, 8'h0);
      bus(1'b1, 6'h12, 8'hc5, 8'h0);
      bus(1'b0, 6'h12, 8'h0, 8'h0);
      bus(1'b1, pfd_pkg::IDX_CMD, pfd_pkg::KEY_UNLOCK, 8'h0);
      bus(1'b1, 6'h12, 8'hc5, 8'h0);
      bus(1'b0, 6'h12, 8'h0, 8'hc5);
      see(2);
      chk({8'h0, pin_oe}, 12'h00c);
      u_env.drive(2'h3, 4'ha);
      for (int i = 0; i < 13; i++) begin
         bus(1'b1, 6'h10, {4'h0, tc[i]}, 8'h0);
         u_env.drive(2'h2, 4'ha);
         see(3);
         chk({pin_level, 3'h0, seq_req_a}, ev[i]);
         u_env.drive(2'h3, 4'ha);
         see(3);
         chk({pin_level, 3'h0, seq_req_a}, 12'ha00);
      end
      bus(1'b1, 6'h10, 8'h07, 8'h0);
      u_env.drive(2'h2, 4'ha);
      u_env.drive(2'h3, 4'ha);
      see(3);
      chk({pin_level, 8'h0}, 12'h500);
      bus(1'b1, pfd_pkg::IDX_CMD, pfd_pkg::KEY_RESUME, 8'h0);
      see(3);
      chk({pin_level, 8'h0}, 12'ha00);
      for (int c = 8; c < 10; c++) begin
         bus(1'b1, 6'h10, 8'(c), 8'h0);
         u_env.drive(2'h2, 4'ha);
         u_env.drive(2'h3, 4'ha);
         see(3);
         chk({pin_level, 8'h0}, 12'hb00);
         u_env.pulse(3);
         see(3);
         chk({pin_level, 8'h0}, 12'ha00);
      end
      bus(1'b1, 6'h10, 8'h00, 8'h0);
      bus(1'b1, pfd_pkg::IDX_EDGE, 8'h01, 8'h0);
      bus(1'b1, 6'h10, 8'h04, 8'h0);
      see(3);
      chk({pin_level, 8'h0}, 12'h500);
      u_env.drive(2'h2, 4'ha);
      see(3);
      chk({pin_level, 8'h0}, 12'ha00);
      bus(1'b1, 6'h10, 8'h00, 8'h0);
      u_env.drive(2'h3, 4'ha);
      bus(1'b1, pfd_pkg::IDX_EDGE, 8'h00, 8'h0);
      bus(1'b1, 6'h11, 8'h03, 8'h0);
      u_env.drive(2'h1, 4'ha);
      see(3);
      chk({pin_level, 3'h0, seq_req_b}, 12'h808);
      u_env.drive(2'h3, 4'ha);
      bus(1'b1, 6'h11, 8'h00, 8'h0);
      for (int k = 0; k < 16; k++) begin
         v = 8'h1 + (8'($random(seed)) & 8'h07);
         bus(1'b1, 6'h15, v, 8'h0);
         bus(1'b1, 6'h14, {2'h0, 2'(k), 2'(k >> 2), pfd_pkg::DF_EVENT}, 8'h0);
         u_env.pulse(k >> 2);
         n = 0;
         #1;
         while (delayed_event !== 1'b1 && n < 200) begin
            @(posedge clk_sys);
            #1;
            n++;
         end
         chk(12'(n), {4'h0, v} << (k & 3));
      end
      bus(1'b1, 6'h15, 8'h04, 8'h0);
      bus(1'b1, 6'h14, 8'h01, 8'h0);
      u_env.pulse(0);
      #1;
      chk({11'h0, blanking}, 12'h001);
      see(6);
      chk({11'h0, blanking}, 12'h000);
      @(posedge clk_sys);
      fuse     <= 8'($random(seed));
      por_flag <= 1'b0;
      rst      <= 1'b1;
      see(2);
      chk({4'h0, pin_oe, pin_level}, {4'h0, fuse});
      @(posedge clk_sys);
      rst <= 1'b0;
      bus(1'b0, 6'h12, 8'h0, fuse);
      see(2);
      print_verdict();
   end
endmodule
bind pfd_fault_delay pfd_checker u_chk (.clk_sys, .rst, .avs_read, .avs_write,
   .avs_waitrequest, .avs_readdata, .pin_oe, .match, .seq_req_a, .blanking, .delayed_event);
`default_nettype wire
